// ---- inc/iowd_pkg.sv ----
package iowd_pkg;
  // host i/o port write, as seen by the card
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } iowd_io_wr_t;

  localparam logic [7:0] IOWD_PORT_ADDR     = 8'h76;
  localparam logic [7:0] IOWD_CODE_DISABLE  = 8'h00;
  localparam int         IOWD_BIT_ENABLE    = 7;
  localparam int         IOWD_BIT_IRQ_MODE  = 6;
  localparam logic [7:0] IOWD_CODE_MASK     = 8'h38;
  localparam logic [2:0] IOWD_CTRL_RESET    = 3'h0;

  // time base: clock rate and a half base unit of 3 s
  localparam int unsigned IOWD_CLK_HZ       = 10_000_000;
  localparam int unsigned IOWD_HALF_UNIT_S  = 3;
  localparam int unsigned IOWD_HALF_UNIT_CYC = IOWD_CLK_HZ * IOWD_HALF_UNIT_S;
  // periods in half units: 3,6,12,18,24,30,36,42 s
  localparam logic [3:0] IOWD_SEL0_HALVES   = 4'h1;
  localparam int unsigned IOWD_RST_PULSE_CYC = 16;
  localparam int unsigned IOWD_BLINK_HALF_CYC = 2_500_000;

  typedef enum logic [1:0] {
    IOWD_IDLE  = 2'b00,
    IOWD_COUNT = 2'b01,
    IOWD_FIRE  = 2'b11
  } iowd_state_t;
endpackage : iowd_pkg

// ---- sim/iowd_host.sv ----
`timescale 1ns/1ps
module iowd_host
  import iowd_pkg::*;
(
  input  wire logic  clk,
  output iowd_io_wr_t io_wr
);
  initial io_wr = '0;
  // released lines show inverted junk, never the old byte
  // a lets a write go to another port, which the card must ignore
  task put(input logic [7:0] d, input logic [7:0] a = IOWD_PORT_ADDR);
    @(posedge clk);
    io_wr <= '{1'b1, a, d};
    @(posedge clk);
    io_wr <= ~io_wr;
  endtask : put
endmodule : iowd_host

// ---- sim/iowd_properties.sv ----
`timescale 1ns/1ps
module iowd_properties
  import iowd_pkg::*;
#(parameter int unsigned HALF_UNIT_CYC = 10) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire iowd_io_wr_t io_wr,
  input wire logic        sys_rst_pulse,
  input wire logic        irq15,
  input wire logic        led
);
  wire hit = io_wr.wr && io_wr.addr == IOWD_PORT_ADDR;
  wire off = hit && io_wr.data == IOWD_CODE_DISABLE;
  int  since_r;
  // only valid codes restart the count
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) since_r <= 0;
    else since_r <= (hit && io_wr.data[7] && !(|(io_wr.data & IOWD_CODE_MASK))) ? 0 : since_r + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence pulse_s; ##15 sys_rst_pulse ##1 !sys_rst_pulse; endsequence
  chk_reset_quiet: assert property ($rose(nrst) |-> !(sys_rst_pulse || irq15 || led)) else $error("busy");
  chk_pulse_width: assert property ($rose(sys_rst_pulse) |-> pulse_s) else $error("width");
  chk_fire_early: assert property ($rose(sys_rst_pulse) |-> since_r >= HALF_UNIT_CYC - 2) else $error("early");
  chk_irq_early: assert property ($rose(irq15) |-> since_r >= HALF_UNIT_CYC - 2) else $error("irq early");
  chk_write_clears_irq: assert property (hit |=> !irq15) else $error("irq kept");
  chk_off_led: assert property (off |-> ##2 !led) else $error("led on");
  chk_off_silent: assert property (off && !sys_rst_pulse |=> !(sys_rst_pulse || irq15) [*8]) else $error("act");
  chk_led_blink: assert property (led |-> ##[1:7] !led) else $error("led stuck");
endmodule : iowd_properties
bind iowd_top iowd_properties #(.HALF_UNIT_CYC(HALF_UNIT_CYC)) iowd_properties_i (.clk(clk), .nrst(nrst),
  .io_wr(io_wr), .sys_rst_pulse(sys_rst_pulse), .irq15(irq15), .led(led));

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  localparam int H = 10;
  logic        clk = 0;
  logic        nrst = 0;
  logic        pulse, irq, led;
  iowd_pkg::iowd_io_wr_t io_wr;
  int          miscompares = 0, tests_run = 0, n, k, e;
  iowd_top #(.HALF_UNIT_CYC(H), .BLINK_HALF_CYC(3)) iowd_top_i (.clk(clk), .nrst(nrst),
    .io_wr(io_wr), .sys_rst_pulse(pulse), .irq15(irq), .led(led));
  iowd_host iowd_host_i (.clk(clk), .io_wr(io_wr));
  initial forever #50 clk = ~clk;
  task check(input string nm, input logic [2:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  // capped wait, so a missing action shows as a bad count
  task upto(input bit i);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((i ? irq : pulse) !== 1'b1 && n < 400);
  endtask : upto
  task print_verdict();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    #2000000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1;
    repeat (30) @(negedge clk);
    check("idle", {pulse, irq, led}, 0);
    for (k = 0; k < 8; k++) begin
      e = H * (k ? 2 * k : 1);
      iowd_host_i.put(8'h87);
      iowd_host_i.put(8'h80 | k[7:0]);
      upto(0);
      check("rst per", n inside {[e - 1 : e + 1]}, 1);
      repeat (16) @(negedge clk);
      check("post", {pulse, irq, led}, 0);
      iowd_host_i.put(8'hc0 | k[7:0]);
      upto(1);
      check("irq per", n inside {[e - 1 : e + 1]}, 1);
      iowd_host_i.put(8'h00);
      repeat (2 * e) @(negedge clk);
      check("off", {pulse, irq, led}, 0);
    end
    iowd_host_i.put(8'h80, 8'h75);
    repeat (30) @(negedge clk);
    check("other port", {pulse, irq, led}, 0);
    iowd_host_i.put(8'h81);
    n = 0;
    repeat (10) begin
      @(negedge clk);
      n += led;
    end
    check("blink", n inside {[3 : 5]}, 1);
    iowd_host_i.put(8'h81);
    repeat (10) @(posedge clk);
    iowd_host_i.put(8'h9f);
    upto(0);
    check("retrig", n inside {[7 : 9]}, 1);
    print_verdict();
  end
endmodule : testbench

// ---- src/iowd_tick.sv ----
`timescale 1ns/1ps
module iowd_tick #(
  parameter int unsigned DIV = 2
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic clr,
  output logic      tick
);
  logic [31:0] cnt_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 32'h0;
    end else if (clr || cnt_r == DIV - 1) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  assign tick = !clr && (cnt_r == DIV - 1);
endmodule : iowd_tick

// ---- src/iowd_top.sv ----
// Functional notes
// - reset leaves watchdog disabled, not counting
// - led blinks only while counting
// - trigger write clears count and restarts, except while a reset pulse is under way
// - expiry fires reset pulse or irq15
// - periods from half unit, 6 s base
// - codes 80h-87h: reset mode, 3-42 s
// - codes c0h-c7h: irq15 mode, 3-42 s
// - valid code to port 76h enables watchdog, except while a reset pulse is under way
// - new factor applies from its write
// - writing 00h disables everything except a reset pulse already under way
// - irq mode interrupts only at expiry, not on enable
`timescale 1ns/1ps
module iowd_top
  import iowd_pkg::*;
#(
  parameter int unsigned HALF_UNIT_CYC = IOWD_HALF_UNIT_CYC,
  parameter int unsigned BLINK_HALF_CYC = IOWD_BLINK_HALF_CYC,
  parameter int unsigned RST_PULSE_CYC = IOWD_RST_PULSE_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire iowd_io_wr_t io_wr,
  output logic             sys_rst_pulse,
  output logic             irq15,
  output logic             led
);
  iowd_state_t state_r;
  logic [7:0]  factor_r;
  logic [3:0]  halves_r;
  logic [3:0]  limit;
  logic        hit;
  logic        valid;
  logic        restart;
  logic        half_tick;
  logic        blink_tick;
  logic [7:0]  pulse_r;
  logic        irq_r;
  logic        led_r;

  // port decode; invalid bytes other than 00h on the port only clear irq15
  assign hit   = io_wr.wr && io_wr.addr == IOWD_PORT_ADDR;
  assign valid = hit && io_wr.data[IOWD_BIT_ENABLE]
                 && (io_wr.data & IOWD_CODE_MASK) == 8'h00;
  // every valid write restarts, same byte or a new one
  assign restart = valid;

  // selected period in half units: 1, then 2*sel
  always_comb begin
    if (factor_r[2:0] == 3'h0) begin
      limit = IOWD_SEL0_HALVES;
    end else begin
      limit = {factor_r[2:0], 1'b0};
    end
  end

  iowd_tick #(.DIV(HALF_UNIT_CYC)) u_base (
    .clk  (clk),
    .nrst (nrst),
    .clr  (restart || state_r != IOWD_COUNT),
    .tick (half_tick)
  );

  iowd_tick #(.DIV(BLINK_HALF_CYC)) u_blink (
    .clk  (clk),
    .nrst (nrst),
    .clr  (state_r != IOWD_COUNT),
    .tick (blink_tick)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      factor_r <= 8'h00;
    end else if (valid) begin
      factor_r <= io_wr.data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= IOWD_IDLE;
    end else begin
      case (state_r)
        IOWD_IDLE: begin
          if (valid) begin
            state_r <= IOWD_COUNT;
          end
        end
        IOWD_COUNT: begin
          if (hit && io_wr.data == IOWD_CODE_DISABLE) begin
            state_r <= IOWD_IDLE;
          end else if (!valid && half_tick && halves_r + 4'h1 >= limit) begin
            // irq mode keeps counting; the irq line is left raised
            state_r <= factor_r[IOWD_BIT_IRQ_MODE] ? IOWD_COUNT : IOWD_FIRE;
          end
        end
        IOWD_FIRE: begin
          if (pulse_r == RST_PULSE_CYC[7:0] - 8'h1) begin
            state_r <= IOWD_IDLE;
          end
        end
        default: state_r <= IOWD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      halves_r <= 4'h0;
    end else if (restart || state_r != IOWD_COUNT) begin
      halves_r <= 4'h0;
    end else if (half_tick) begin
      halves_r <= (halves_r + 4'h1 >= limit) ? 4'h0 : halves_r + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_r <= 8'h00;
    end else if (state_r == IOWD_FIRE) begin
      pulse_r <= pulse_r + 8'h1;
    end else begin
      pulse_r <= 8'h00;
    end
  end

  // irq stays high until rewritten, disabled or reset; the enabling
  // write clears it, so no stale line shows when software unmasks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else if (hit) begin
      irq_r <= 1'b0;
    end else if (state_r == IOWD_COUNT && factor_r[IOWD_BIT_IRQ_MODE]
                 && half_tick && halves_r + 4'h1 >= limit) begin
      irq_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      led_r <= 1'b0;
    end else if (state_r != IOWD_COUNT) begin
      led_r <= 1'b0;
    end else if (blink_tick) begin
      led_r <= ~led_r;
    end
  end

  assign sys_rst_pulse = state_r == IOWD_FIRE;
  assign irq15         = irq_r;
  assign led           = led_r;
endmodule : iowd_top
